// ### common/ckdx_pkg.sv
// Package: constants and carriers for the clock divider and exception synchroniser
package ckdx_pkg;
  localparam int unsigned SYS_CLK_HZ     = 40000000; // System clock rate
  localparam int unsigned DIV_HALF       = 2;        // Divide ratio, select high
  localparam int unsigned DIV_QUARTER    = 4;        // Divide ratio, select low
  localparam int unsigned SYNC_STAGES    = 3;        // Flip-flops per synchroniser
  localparam int unsigned EXT_IRQ_W      = 6;        // External interrupt lines
  localparam int unsigned EXC_W          = EXT_IRQ_W + 3; // All exception lines
  localparam logic [1:0]  DIV_CNT_RST    = 2'h0;     // Divider phase after reset
  localparam logic        SYNC_RST_VAL   = 1'h0;     // Stage value while input asserted

  // Raw asynchronous exception pins, all active low
  typedef struct packed {
    logic                 cold_reset_n;
    logic                 warm_reset_n;
    logic                 nmi_n;
    logic [EXT_IRQ_W-1:0] ext_irq_n;
  } ckdx_exc_t;
endpackage

// ### verilog/ckdx_clock_sync.sv
// Design: system clock fan-out, local bus clock divider and exception synchronisers
// Function
// - The system clock is passed out unchanged in rate as the memory clock.
// - The local bus clock is the system clock divided by two or by four.
// - With the select pin low the local bus clock runs at a quarter rate.
// - With the select pin high the local bus clock runs at half rate.
// - The divided clock feeds the bus bridge unit and is driven out to the bus.
// - All local bus parties sample and change on the local bus clock rising edge.
// - Cold reset, warm reset, NMI and six interrupts are synchronised to clk.
// - Each synchroniser is a flip-flop chain whose first stage the input resets.
// - A release appears on the third rising clock edge, an assertion on the second.
`timescale 1ns/1ps
`default_nettype none

module ckdx_clock_sync #(
  parameter int unsigned STAGES = ckdx_pkg::SYNC_STAGES // Synchroniser depth
) (
  input  wire logic              clk,                 // System clock, 40 MHz
  input  wire logic              rst_b,               // Async reset, active low
  input  wire logic              clk_en,              // Freezes all state when low, except the pin clear of stage A
  input  wire logic              quarter_rate_sel_n,  // Low selects divide by four
  input  wire ckdx_pkg::ckdx_exc_t exc_in_n,          // Raw async exception pins
  output logic                   mem_clk_out,         // System clock on a plain wire
  output logic                   local_bus_clk,       // Divided bus clock, to pin
  output logic                   bus_bridge_clk,      // Same clock, for the bridge
  output ckdx_pkg::ckdx_exc_t    exc_sync_n           // Synchronised exceptions
);

  // Refuse a chain too short to give any metastability margin
  if (STAGES < 2) begin : g_bad_stages
    $error("ckdx_clock_sync: STAGES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock fan-out
  // Plain wire: a gate here would skew memory clock against internal timing
  assign mem_clk_out = clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Divider phase walk from reset, one line per enabled edge:
  //   edge    1 2 3 4 5 6 7 8
  //   half    1 0 1 0 1 0 1 0
  //   quarter 0 1 1 0 0 1 1 0
  // The quarter output looks one count ahead, so it reaches its first high
  // level on edge 2 and stays in step with counter bit 1 from then on.
  // A select change outside reset gives one odd phase but never a runt pulse,
  // because the pin is always driven from a flip-flop.
  // Divider: two-bit counter, bit 0 toggles for /2, bit 1 for /4
  logic [1:0] div_cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= ckdx_pkg::DIV_CNT_RST;
    end else if (clk_en) begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // Registered output so the pin never glitches; select assumed static
  logic bus_clk_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_clk_q <= 1'h0;
    end else if (clk_en) begin
      if (!quarter_rate_sel_n) begin
        bus_clk_q <= next_div_q4(div_cnt);
      end else begin
        bus_clk_q <= ~div_cnt[0];
      end
    end
  end

  function automatic logic next_div_q4(input logic [1:0] cnt);
    logic [1:0] nxt;
    nxt = cnt + 2'h1;
    return nxt[1];
  endfunction

  // Both parties on the bus use this edge
  assign local_bus_clk  = bus_clk_q;
  assign bus_bridge_clk = bus_clk_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Exception synchronisers: raw low level resets the first stage directly
  logic [ckdx_pkg::EXC_W-1:0] raw_n;
  logic [ckdx_pkg::EXC_W-1:0] stage_a;
  logic [ckdx_pkg::EXC_W-1:0] chain [STAGES-1];
  assign raw_n = exc_in_n;

  genvar g;
  generate
    for (g = 0; g < ckdx_pkg::EXC_W; g++) begin : g_sync
      logic stage_q; // Flip-flop A of this line
      // First stage: async clear by the pin itself, also by system reset
      always_ff @(posedge clk or negedge rst_b or negedge raw_n[g]) begin
        if (!rst_b) begin
          stage_q <= ckdx_pkg::SYNC_RST_VAL;
        end else if (!raw_n[g]) begin
          stage_q <= ckdx_pkg::SYNC_RST_VAL;
        end else if (clk_en) begin
          stage_q <= 1'h1;
        end
      end
      assign stage_a[g] = stage_q;
    end
  endgenerate

  // Later stages; stage_a read only by the next flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STAGES - 1; i++) begin
        chain[i] <= '0;
      end
    end else if (clk_en) begin
      chain[0] <= stage_a;
      for (int i = 1; i < STAGES - 1; i++) begin
        chain[i] <= chain[i-1];
      end
    end
  end

  assign exc_sync_n = chain[STAGES-2];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Run length of the bus clock level, counted in enabled cycles only, so a
  // freeze does not look like a stretched phase
  logic [2:0] lo_cnt;
  logic       bus_prev;
  logic       run_seen; // First toggle seen; the reset level outlasts a run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_cnt   <= 3'h0;
      bus_prev <= 1'h0;
    end else if (clk_en) begin
      bus_prev <= bus_clk_q;
      if (bus_clk_q != bus_prev) begin
        lo_cnt <= 3'h0;
      end else if (lo_cnt != 3'h7) begin
        lo_cnt <= lo_cnt + 3'h1;
      end
    end
  end

  // Set by the first toggle after reset, cleared only by reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_seen <= 1'h0;
    end else if (clk_en && (bus_clk_q != bus_prev)) begin
      run_seen <= 1'h1;
    end
  end

  half_rate_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(rst_b) && clk_en && $past(clk_en) && quarter_rate_sel_n &&
     $past(quarter_rate_sel_n))
      |-> bus_clk_q != $past(bus_clk_q))
    else $error("half rate bus clock did not toggle");

  quarter_rate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!quarter_rate_sel_n && clk_en && run_seen) |-> lo_cnt <= 3'h1)
    else $error("quarter rate bus clock held too long");

  quarter_phase_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!quarter_rate_sel_n && clk_en && $past(clk_en) && $past(quarter_rate_sel_n) == 1'b0)
      |-> bus_clk_q == div_cnt[1])
    else $error("quarter rate clock out of phase with counter");

  bridge_same_a: assert property (@(posedge clk) disable iff (!rst_b)
    local_bus_clk == bus_bridge_clk)
    else $error("bridge clock differs from bus clock");

  // High phase seen just before the falling edge, low phase before the rising
  mem_clk_a: assert property (@(negedge clk) disable iff (!rst_b)
    mem_clk_out == 1'b1)
    else $error("memory clock not following system clock");

  mem_clk_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    mem_clk_out == 1'b0)
    else $error("memory clock high before system clock rise");

  div_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    !clk_en |=> ($stable(bus_clk_q) && $stable(div_cnt)))
    else $error("divider moved while clock enable low");

  sync_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    !clk_en |=> $stable(exc_sync_n))
    else $error("synchroniser output moved while clock enable low");

  sync_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en [*3]) |-> exc_sync_n == $past(stage_a, 2))
    else $error("synchronised exception not two flops after first stage");

  first_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    !raw_n[0] |-> stage_a[0] == 1'b0)
    else $error("first stage not cleared by asserted input");

  assert_path_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!raw_n[7] && clk_en) [*3] |-> !exc_sync_n.warm_reset_n)
    else $error("held warm reset not seen after three edges");

  cold_path_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!raw_n[8] && clk_en) [*3] |-> !exc_sync_n.cold_reset_n)
    else $error("held cold reset not seen after three edges");

  nmi_path_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!raw_n[6] && clk_en) [*3] |-> !exc_sync_n.nmi_n)
    else $error("held nonmaskable interrupt not seen after three edges");

  // Keyed on stage A, since a short pin pulse between edges still clears it
  release_path_a: assert property (@(posedge clk) disable iff (!rst_b)
    (stage_a[0] && clk_en) [*3] |-> exc_sync_n.ext_irq_n[0])
    else $error("released interrupt not seen after settling");

  quarter_run_c: cover property (@(posedge clk) disable iff (!rst_b)
    !quarter_rate_sel_n && $rose(bus_clk_q));
  half_run_c: cover property (@(posedge clk) disable iff (!rst_b)
    quarter_rate_sel_n && $fell(bus_clk_q));
  cold_reset_c: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(exc_sync_n.cold_reset_n));
  warm_reset_c: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(exc_sync_n.warm_reset_n));
  freeze_c: cover property (@(posedge clk) disable iff (!rst_b)
    !clk_en ##1 clk_en);

endmodule

`default_nettype wire

// ### tb/ckdx_bus_dev.sv
// Partner: a local bus device that counts bus clock rising edges
`timescale 1ns/1ps
`default_nettype none

module ckdx_bus_dev (
  input  wire logic            bus_clk, // Local bus clock from the pin
  output var  int unsigned     n_rise   // Rising edges seen so far
);
  // Devices act on the rising edge only; a falling-edge count would hide a duty fault
  initial n_rise = 0;
  always @(posedge bus_clk) begin
    n_rise <= n_rise + 1;
  end
endmodule

`default_nettype wire

// ### tb/ckdx_clock_sync_tb_top.sv
// Testbench: divider phases, clock fan-out and exception synchronisers
`timescale 1ns/1ps
`default_nettype none
`define CKDX_CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end

module ckdx_clock_sync_tb_top;
  logic                clk;
  logic                rst_b;
  logic                clk_en;
  logic                quarter_rate_sel_n;
  ckdx_pkg::ckdx_exc_t exc_in_n;
  logic                mem_clk_out;
  logic                local_bus_clk;
  logic                bus_bridge_clk;
  ckdx_pkg::ckdx_exc_t exc_sync_n;
  int unsigned         n_rise;
  int                  n_fail;
  int                  cmp_count;

  ckdx_clock_sync u_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .quarter_rate_sel_n(quarter_rate_sel_n), .exc_in_n(exc_in_n), .mem_clk_out(mem_clk_out),
    .local_bus_clk(local_bus_clk), .bus_bridge_clk(bus_bridge_clk), .exc_sync_n(exc_sync_n));
  ckdx_bus_dev u_dev (.bus_clk(local_bus_clk), .n_rise(n_rise));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Select only moves in reset, so the divider never sees a mid-run change
  task automatic restart(input logic sel);
    @(negedge clk);
    rst_b = 1'b0;
    quarter_rate_sel_n = sel;
    exc_in_n = '1;
    repeat (10) @(negedge clk);
    `CKDX_CHK("bus_clk_rst", 1'b0, local_bus_clk)
    `CKDX_CHK("sync_rst", 9'h000, exc_sync_n)
    rst_b = 1'b1;
  endtask

  // Walk the divider from reset, then freeze it
  task automatic check_div(input logic sel);
    int unsigned r0;
    restart(sel);
    r0 = n_rise;
    for (int k = 1; k <= 8; k++) begin
      @(posedge clk);
      #1;
      `CKDX_CHK("mem_clk_hi", 1'b1, mem_clk_out)
      @(negedge clk);
      `CKDX_CHK("mem_clk_lo", 1'b0, mem_clk_out)
      `CKDX_CHK("bus_clk", 1'((sel ? k : k >> 1) & 1), local_bus_clk)
      `CKDX_CHK("bridge_clk", 1'((sel ? k : k >> 1) & 1), bus_bridge_clk)
    end
    `CKDX_CHK("bus_rises", (sel ? 4 : 2), n_rise - r0)
    clk_en = 1'b0;
    repeat (3) @(negedge clk);
    `CKDX_CHK("frozen_clk", 1'b0, local_bus_clk)
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    `CKDX_CHK("resumed_clk", !sel, local_bus_clk)
  endtask

  // Release latency, then short pulses between edges on every pin
  task automatic check_sync();
    logic [8:0] m;
    restart(1'b1);
    for (int k = 1; k <= 3; k++) begin
      @(negedge clk);
      `CKDX_CHK("sync_rel", (k == 3) ? 9'h1FF : 9'h000, exc_sync_n)
    end
    for (int p = 0; p < 2; p++) begin
      m = p ? 9'h0AA : 9'h155;
      #2 exc_in_n = ~m;
      #3 exc_in_n = '1;
      @(negedge clk);
      `CKDX_CHK("sync_e1", 9'h1FF, exc_sync_n)
      @(negedge clk);
      `CKDX_CHK("sync_e2", ~m, exc_sync_n)
      @(negedge clk);
      `CKDX_CHK("sync_e3", 9'h1FF, exc_sync_n)
    end
    exc_in_n = '0;
    repeat (2) @(negedge clk);
    `CKDX_CHK("sync_hold", 9'h000, exc_sync_n)
    repeat (2) @(negedge clk);
    exc_in_n = '1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    quarter_rate_sel_n = 1'b1;
    exc_in_n = '1;
    n_fail = 0;
    cmp_count = 0;
    check_div(1'b1);
    check_div(1'b0);
    check_sync();
    conclude();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule

`default_nettype wire
